//--- core/tla_pkg.sv
// Constants shared by the tick loss adjuster block
package tla_pkg;
    localparam int          CLK_HZ         = 250_000_000;
    localparam int          PULSE_RATE_HZ  = 60;
    localparam int          PULSE_DIV      = CLK_HZ / PULSE_RATE_HZ;

    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 8;
    localparam int          COUNT_W        = 24;
    localparam int          FIELD_W        = 6;

    localparam logic [15:0] ADDR_FEATURE   = 16'h7000;
    localparam logic [15:0] ADDR_LOCATION  = 16'h7001;
    localparam logic [15:0] ADDR_CHECK     = 16'h700A;
    localparam logic [15:0] ADDR_CNT_LOW   = 16'h700B;
    localparam logic [15:0] ADDR_CNT_MLOW  = 16'h700C;
    localparam logic [15:0] ADDR_CNT_MHIGH = 16'h700D;
    localparam logic [15:0] ADDR_CNT_HIGH  = 16'h700E;

    localparam logic [7:0]  CHECK_GOOD     = 8'h55;
    localparam logic [7:0]  CHECK_LOST     = 8'h00;
    localparam logic [7:0]  DATA_ZERO      = 8'h00;
    localparam logic [23:0] COUNT_ZERO     = 24'h000000;
    localparam logic [23:0] COUNT_ONE      = 24'h000001;
    localparam logic [3:0]  SAT_MASK       = 4'hF;

    localparam int          SAT_LSB        = 20;
    localparam int          MLOW_LSB       = 6;
    localparam int          MHIGH_LSB      = 12;
    localparam int          HIGH_LSB       = 18;
    localparam int          LOCK_BIT       = 6;
    localparam int          TYPE_BIT       = 7;
endpackage : tla_pkg

//--- core/tla_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module tla_sync
    import tla_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_stage2;

    always_comb begin
        next_stage1 = ce_i ? async_i : stage1;
        next_stage2 = ce_i ? stage1 : stage2;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign sync_o = stage2;
endmodule : tla_sync

//--- core/tla_mains_rate_pulser.sv
// Free-running mains-rate pulse generator derived from the reference clock
`timescale 1ns/100ps
module tla_mains_rate_pulser
    import tla_pkg::*;
#(
    parameter int DIV = PULSE_DIV
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    input  wire logic ce_i,
    input  wire logic run_i,
    output logic      tick_o
);
    logic [31:0] div_cnt;
    logic [31:0] next_div_cnt;
    logic        wrap;

    // Divider keeps running while disabled; only the pulse is gated
    assign wrap = (div_cnt == 32'(DIV - 1));

    always_comb begin
        next_div_cnt = div_cnt;
        if (ce_i) begin
            next_div_cnt = wrap ? 32'h00000000 : div_cnt + 32'h00000001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_cnt <= 32'h00000000;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    assign tick_o = ce_i && run_i && wrap;
endmodule : tla_mains_rate_pulser

//--- core/tla_tick_loss_adjuster.sv
// Tick loss adjuster: mains-rate tick counter, id switch ports, write lock
//
// Function
// - Feature switches read at 7000, location switches read at 7001.
// - Eight switches per bank; switch n drives data bit n.
// - Switch ON reads as 1, OFF reads as 0.
// - 24-bit binary counter counts pulses of a free-running 60 Hz generator.
// - Counter increments by one per pulse; a write to 700A or rst_b_i clears it.
// - Counter bits 21 to 24 all ones disable the pulse generator.
// - Counter bit 1 is the least significant, bit 24 the most.
// - Counter value shown continuously on four read ports, no latch needed.
// - Ports 700B-700E carry counter bits 1-6, 7-12, 13-18, 19-24; read-only.
// - Port 700A reads 55 hex while standby power is healthy.
// - Counter and generator keep state through main supply loss; here rst_b_i clears both along with all other state.
// - Port 700E bit 8 always reads 1 to identify the module type.
// - Port 700E bit 7 shows write-lock state, 1 when active.
// - Each write to 7000 toggles the SRAM write lock.
`timescale 1ns/100ps
module tla_tick_loss_adjuster
    import tla_pkg::*;
#(
    parameter int PULSE_DIV_CYC = PULSE_DIV
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              ce_i,
    input  wire logic [ADDR_W-1:0] host_addr_i,
    input  wire logic              host_rd_i,
    input  wire logic              host_wr_i,
    input  wire logic [DATA_W-1:0] feature_sw_i,
    input  wire logic [DATA_W-1:0] location_sw_i,
    input  wire logic              standby_ok_i,
    output logic      [DATA_W-1:0] data_o,
    output logic                   data_oe_o,
    output logic                   sram_write_lock_o
);
    logic [DATA_W-1:0]  feat_s;
    logic [DATA_W-1:0]  loc_s;
    logic               standby_s;
    logic               tick;
    logic               sat;
    logic               clr;
    logic               lock_wr;
    logic               hit;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] next_count;
    logic               lock;
    logic               next_lock;
    logic [DATA_W-1:0]  rd_data;
    logic [DATA_W-1:0]  next_rd_data;
    logic               rd_oe;
    logic               next_rd_oe;

    // Pins cross in through two flops each
    tla_sync #(
        .W (2 * DATA_W + 1)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .async_i   ({standby_ok_i, location_sw_i, feature_sw_i}),
        .sync_o    ({standby_s, loc_s, feat_s})
    );

    // Generator pulse is gated off once the top four bits saturate; its divider keeps running
    assign sat = (count[SAT_LSB +: 4] == SAT_MASK);

    tla_mains_rate_pulser #(
        .DIV (PULSE_DIV_CYC)
    ) u_pulser (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .run_i     (!sat),
        .tick_o    (tick)
    );

    function automatic logic [DATA_W-1:0] field6(input logic [FIELD_W-1:0] f);
        field6 = {2'h0, f};
    endfunction : field6

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        addr_is = (a == b);
    endfunction : addr_is

    assign clr     = ce_i && host_wr_i && addr_is(host_addr_i, ADDR_CHECK);
    assign lock_wr = ce_i && host_wr_i && addr_is(host_addr_i, ADDR_FEATURE);

    // Counter state is cleared by rst_b_i like the lock and read registers; there is no separate standby reset
    always_comb begin
        next_count = count;
        if (clr) begin
            next_count = COUNT_ZERO;
        end else if (tick) begin
            next_count = count + COUNT_ONE;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= COUNT_ZERO;
        end else begin
            count <= next_count;
        end
    end

    always_comb begin
        next_lock = lock;
        if (lock_wr) begin
            next_lock = !lock;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lock <= 1'b0;
        end else begin
            lock <= next_lock;
        end
    end

    assign sram_write_lock_o = lock;

    // Read decode; unmapped addresses leave the data bus undriven
    always_comb begin
        next_rd_data = rd_data;
        next_rd_oe   = rd_oe;
        hit          = 1'b1;
        if (ce_i) begin
            next_rd_data = DATA_ZERO;
            if (addr_is(host_addr_i, ADDR_FEATURE)) begin
                next_rd_data = feat_s;
            end else if (addr_is(host_addr_i, ADDR_LOCATION)) begin
                next_rd_data = loc_s;
            end else if (addr_is(host_addr_i, ADDR_CHECK)) begin
                next_rd_data = standby_s ? CHECK_GOOD : CHECK_LOST;
            end else if (addr_is(host_addr_i, ADDR_CNT_LOW)) begin
                next_rd_data = field6(count[0 +: FIELD_W]);
            end else if (addr_is(host_addr_i, ADDR_CNT_MLOW)) begin
                next_rd_data = field6(count[MLOW_LSB +: FIELD_W]);
            end else if (addr_is(host_addr_i, ADDR_CNT_MHIGH)) begin
                next_rd_data = field6(count[MHIGH_LSB +: FIELD_W]);
            end else if (addr_is(host_addr_i, ADDR_CNT_HIGH)) begin
                next_rd_data = field6(count[HIGH_LSB +: FIELD_W]);
                next_rd_data[LOCK_BIT] = lock;
                next_rd_data[TYPE_BIT] = 1'b1;
            end else begin
                hit = 1'b0;
            end
            next_rd_oe = host_rd_i && hit;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data <= DATA_ZERO;
            rd_oe   <= 1'b0;
        end else begin
            rd_data <= next_rd_data;
            rd_oe   <= next_rd_oe;
        end
    end

    assign data_o    = rd_data;
    assign data_oe_o = rd_oe;

    sequence s_clear_write;
        ce_i && host_wr_i && host_addr_i == ADDR_CHECK;
    endsequence

    sequence s_count_zero;
        count == COUNT_ZERO;
    endsequence

    a_count_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_clear_write |=> s_count_zero)
        else $error("counter not cleared by write to check port");

    a_count_step: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        tick && !clr |=> count == $past(count) + COUNT_ONE)
        else $error("counter did not step by one on a pulse");

    a_sat_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        sat && !clr |=> count == $past(count))
        else $error("saturated counter moved");

    a_lock_toggle: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        lock_wr |=> sram_write_lock_o != $past(sram_write_lock_o))
        else $error("write lock did not toggle");

    a_check_good: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && host_rd_i && host_addr_i == ADDR_CHECK && standby_s |=> data_o == CHECK_GOOD && data_oe_o)
        else $error("check port wrong with standby present");

    a_check_lost: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && host_rd_i && host_addr_i == ADDR_CHECK && !standby_s |=> data_o != CHECK_GOOD)
        else $error("check port reads good with standby lost");

    a_high_port: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && host_rd_i && host_addr_i == ADDR_CNT_HIGH |=> data_o[TYPE_BIT] && data_oe_o)
        else $error("type bit not set on high count port");

    a_lock_view: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && host_rd_i && host_addr_i == ADDR_CNT_HIGH |=> data_o[LOCK_BIT] == $past(lock))
        else $error("lock bit mismatch on high count port");

    a_low_port: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && host_rd_i && host_addr_i == ADDR_CNT_LOW |=> data_o == field6($past(count[0 +: FIELD_W])))
        else $error("low count port mismatch");

    a_feature_port: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && host_rd_i && host_addr_i == ADDR_FEATURE |=> data_o == $past(feat_s))
        else $error("feature switch port mismatch");

    a_oe_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && !host_rd_i |=> !data_oe_o)
        else $error("data driven without a read");

    sequence s_unmapped_read;
        ce_i && host_rd_i && host_addr_i != ADDR_FEATURE && host_addr_i != ADDR_LOCATION
        && host_addr_i != ADDR_CHECK && host_addr_i != ADDR_CNT_LOW && host_addr_i != ADDR_CNT_MLOW
        && host_addr_i != ADDR_CNT_MHIGH && host_addr_i != ADDR_CNT_HIGH;
    endsequence

    sequence s_count_read;
        ce_i && host_rd_i && (host_addr_i == ADDR_CNT_LOW || host_addr_i == ADDR_CNT_MLOW
        || host_addr_i == ADDR_CNT_MHIGH || host_addr_i == ADDR_CNT_HIGH);
    endsequence

    a_unmapped_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_unmapped_read |=> !data_oe_o && data_o == DATA_ZERO)
        else $error("unmapped read drove the data bus");

    a_count_oe: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_count_read |=> data_oe_o)
        else $error("count port read left the bus undriven");

    a_loc_port: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && host_rd_i && host_addr_i == ADDR_LOCATION |=> data_o == $past(loc_s) && data_oe_o)
        else $error("location switch port mismatch");

    a_mlow_port: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && host_rd_i && host_addr_i == ADDR_CNT_MLOW |=> data_o == field6($past(count[MLOW_LSB +: FIELD_W])))
        else $error("mid low count port mismatch");

    a_mhigh_port: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && host_rd_i && host_addr_i == ADDR_CNT_MHIGH |=> data_o == field6($past(count[MHIGH_LSB +: FIELD_W])))
        else $error("mid high count port mismatch");

    a_high_bits: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && host_rd_i && host_addr_i == ADDR_CNT_HIGH
        |=> data_o[FIELD_W-1:0] == $past(count[HIGH_LSB +: FIELD_W]))
        else $error("high count port bits mismatch");

    a_lock_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !(ce_i && host_wr_i && host_addr_i == ADDR_FEATURE) |=> $stable(sram_write_lock_o))
        else $error("write lock moved without a write");

    a_count_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !tick && !clr |=> $stable(count))
        else $error("counter moved without a pulse");

    a_freeze_all: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !ce_i |=> $stable(count) && $stable(lock) && $stable(data_o) && $stable(data_oe_o))
        else $error("state moved while the clock enable was low");

    a_tick_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        sat |-> !tick)
        else $error("pulse passed while the counter is saturated");

    // Spacing watch: ce cycles since the last pulse
    // Untrusted after saturation, since the gap then spans the pulses gated off while saturated
    logic [31:0] tick_gap;
    logic [31:0] next_tick_gap;
    logic        gap_valid;
    logic        next_gap_valid;

    always_comb begin
        next_tick_gap  = tick_gap;
        next_gap_valid = gap_valid;
        if (tick) begin
            next_tick_gap  = 32'h00000000;
            next_gap_valid = 1'b1;
        end else if (ce_i) begin
            next_tick_gap = tick_gap + 32'h00000001;
        end
        if (sat) begin
            next_gap_valid = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_gap  <= 32'h00000000;
            gap_valid <= 1'b1;
        end else begin
            tick_gap  <= next_tick_gap;
            gap_valid <= next_gap_valid;
        end
    end

    a_tick_period: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        tick && gap_valid |-> tick_gap == 32'(PULSE_DIV_CYC - 1))
        else $error("pulse spacing differs from the divider period");
endmodule : tla_tick_loss_adjuster

//--- sim/tla_host_model.sv
// Host processor model issuing single port reads and writes
`timescale 1ns/100ps
module tla_host_model
    import tla_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              data_oe_i,
    output logic      [ADDR_W-1:0] host_addr_o,
    output logic                   host_rd_o,
    output logic                   host_wr_o
);
    initial begin
        host_addr_o = 16'h0000;
        host_rd_o   = 1'b0;
        host_wr_o   = 1'b0;
    end
    // Idle address is inverted so a stale decode never looks like a fresh answer
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic oe);
        @(posedge ref_clk_i) #1;
        host_addr_o = a;
        host_rd_o   = 1'b1;
        @(posedge ref_clk_i) #1;
        d           = data_i;
        oe          = data_oe_i;
        host_rd_o   = 1'b0;
        host_addr_o = ~a;
    endtask : rd
    // One-cycle strobe: a longer one would count as several writes
    task automatic wr(input logic [15:0] a);
        @(posedge ref_clk_i) #1;
        host_addr_o = a;
        host_wr_o   = 1'b1;
        @(posedge ref_clk_i) #1;
        host_wr_o   = 1'b0;
        host_addr_o = ~a;
    endtask : wr
endmodule : tla_host_model

//--- sim/tla_tick_loss_adjuster_tb.sv
// Self-checking bench for the tick loss adjuster
`timescale 1ns/100ps
module tla_tick_loss_adjuster_tb;
    import tla_pkg::*;
    localparam int DIV = 4;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ce = 1'b1;
    logic        sb_ok = 1'b1;
    logic [7:0]  fsw = 8'h00;
    logic [7:0]  lsw = 8'h00;
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  data;
    logic        oe;
    logic        lock;
    logic [7:0]  d;
    logic [7:0]  m;
    logic        e;
    int          failures = 0;
    int          n_tests = 0;

    always #2 ref_clk = ~ref_clk;

    tla_tick_loss_adjuster #(.PULSE_DIV_CYC(DIV)) dut (
        .ref_clk_i(ref_clk), .rst_b_i(rst_b), .ce_i(ce), .host_addr_i(addr),
        .host_rd_i(rd), .host_wr_i(wr), .feature_sw_i(fsw), .location_sw_i(lsw),
        .standby_ok_i(sb_ok), .data_o(data), .data_oe_o(oe), .sram_write_lock_o(lock));

    tla_host_model host (
        .ref_clk_i(ref_clk), .data_i(data), .data_oe_i(oe),
        .host_addr_o(addr), .host_rd_o(rd), .host_wr_o(wr));

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Read a port, expecting the bus to be driven
    task automatic rdp(input logic [15:0] a, output logic [7:0] v);
        host.rd(a, v, e);
        chk("oe", {23'h0, e}, 24'h000001);
    endtask : rdp

    task automatic t_switch;
        for (int i = 0; i < 8; i++) begin
            fsw = 8'h01 << i;
            lsw = ~(8'h01 << i);
            repeat (3) @(posedge ref_clk);
            #1;
            rdp(ADDR_FEATURE, d);
            chk("feature", {16'h0, d}, {16'h0, 8'h01 << i});
            rdp(ADDR_LOCATION, d);
            chk("location", {16'h0, d}, {16'h0, ~(8'h01 << i)});
        end
        $display("done t_switch");
    endtask : t_switch

    task automatic t_check;
        rdp(ADDR_CHECK, d);
        chk("check ok", {16'h0, d}, {16'h0, CHECK_GOOD});
        sb_ok = 1'b0;
        repeat (3) @(posedge ref_clk);
        rdp(ADDR_CHECK, d);
        chk("check lost", {23'h0, d == CHECK_GOOD}, 24'h0);
        sb_ok = 1'b1;
        host.rd(16'h7002, d, e);
        chk("unmapped", {15'h0, e, d}, 24'h0);
        $display("done t_check");
    endtask : t_check

    task automatic t_lock;
        host.wr(ADDR_FEATURE);
        chk("lock set", {23'h0, lock}, 24'h1);
        rdp(ADDR_CNT_HIGH, d);
        chk("high lock", {16'h0, d}, 24'h0000C0);
        host.wr(ADDR_FEATURE);
        chk("lock clr", {23'h0, lock}, 24'h0);
        rdp(ADDR_CNT_HIGH, d);
        chk("high unlock", {16'h0, d}, 24'h000080);
        $display("done t_lock");
    endtask : t_lock

    task automatic t_count;
        host.wr(ADDR_CHECK);
        rdp(ADDR_CNT_LOW, d);
        chk("after clear", {23'h0, d <= 8'h01}, 24'h1);
        repeat (300) @(posedge ref_clk);
        rdp(ADDR_CNT_LOW, d);
        rdp(ADDR_CNT_MLOW, m);
        // About 300 cycles at one tick per DIV cycles
        chk("count", {23'h0, {m[5:0], d[5:0]} >= 12'd74 && {m[5:0], d[5:0]} <= 12'd78}, 24'h1);
        chk("pad bits", {22'h0, m[7:6] | d[7:6]}, 24'h0);
        rdp(ADDR_CNT_MHIGH, d);
        chk("mid high", {16'h0, d}, 24'h0);
        host.wr(ADDR_CHECK);
        rdp(ADDR_CNT_MLOW, m);
        chk("clear mid", {16'h0, m}, 24'h0);
        $display("done t_count");
    endtask : t_count

    task automatic t_hold;
        repeat (40) @(posedge ref_clk);
        rdp(ADDR_CNT_LOW, m);
        ce = 1'b0;
        repeat (40) @(posedge ref_clk);
        #1 ce = 1'b1;
        rdp(ADDR_CNT_LOW, d);
        chk("held", {23'h0, d >= m && d <= m + 8'h02}, 24'h1);
        $display("done t_hold");
    endtask : t_hold

    // Second power-on in mid-run: lock and count return to zero, check port recovers
    task automatic t_reset;
        host.wr(ADDR_FEATURE);
        chk("lock before reset", {23'h0, lock}, 24'h1);
        rst_b = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        chk("reset state", {22'h0, lock, oe}, 24'h0);
        repeat (2) @(posedge ref_clk);
        rdp(ADDR_CNT_LOW, d);
        chk("count after reset", {23'h0, d <= 8'h01}, 24'h1);
        rdp(ADDR_CHECK, d);
        chk("check after reset", {16'h0, d}, {16'h0, CHECK_GOOD});
        $display("done t_reset");
    endtask : t_reset

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    initial begin
        #200000;
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        chk("reset lock", {22'h0, lock, oe}, 24'h0);
        t_switch();
        t_check();
        t_lock();
        t_count();
        t_hold();
        t_reset();
        report_and_stop();
    end
endmodule : tla_tick_loss_adjuster_tb
